// File: rtl/dram_counter_tester.sv
// Controller that refreshes a 64K x 4 DRAM and runs its refresh counter test
// Operation
// - Hidden refresh keeps column strobe low so last read data stays on output.
// - Column strobe rise and fall with row strobe low after refresh starts test access.
// - During test access drive 8 column bits only after the test column delay; the code drives them first and the delay then runs before the strobe falls.
// - Begin verification with eight strobe-order refresh cycles.
// - Use one fixed column address for every access of the procedure.
// - Write zero to all 256 rows at the fixed column with normal writes.
// - Counter test read-modify-write reads zero and writes one for 256 rows.
// - Read all 256 rows normally and check each returns one.
// - Invert the pattern and repeat write, test and read-back steps.
// - Refresh every one of 256 rows at least once per 4 ms.
// - Write strobe high selects read, low selects write or read-modify-write.
`timescale 1ns/1ps
`include "dram_test_regs.svh"
module dram_counter_tester #(
  parameter int REF_CYC = `REF_CYC,
  parameter int INIT_CYCLES = `INIT_CYCLES
) (
  input wire logic clk_in, // System clock, 25 MHz
  input wire logic rst_in, // Synchronous reset, active high
  input wire logic start_in, // Level, starts the counter test when idle
  input wire logic [7:0] col_in, // Fixed column used by the whole test
  input wire logic [3:0] dq_in, // Data pins from the DRAM
  output dram_test_pkg::dram_pins_s pins_out, // Strobes, address and data drive
  output logic busy_out, // Test running
  output logic done_out, // Test finished
  output logic fail_out // A read returned the wrong value
);
  import dram_test_pkg::*;

  if (REF_CYC < 2 || REF_CYC > 511) begin : g_bad_ref
    $error("REF_CYC out of range");
  end
  if (INIT_CYCLES < 1 || INIT_CYCLES > 255) begin : g_bad_init
    $error("INIT_CYCLES out of range");
  end

  seq_e seq, next_seq;
  pin_e pin, next_pin;
  op_e op, next_op;
  dram_pins_s pins, next_pins;
  logic [7:0] wt, next_wt;
  logic [8:0] cnt, next_cnt;
  logic [8:0] ref_t, next_ref_t;
  logic [7:0] col, next_col;
  logic pat, next_pat, second, next_second, ref_pend, next_ref_pend;
  logic busy, next_busy, done, next_done, fail, next_fail;
  logic op_done;
  logic [3:0] dq_sync;

  dram_pin_sync #(.W(4)) u_sync (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .d_in(dq_in),
    .q_out(dq_sync)
  );

  function automatic logic [7:0] cyc(input int n);
    return 8'(n - 1);
  endfunction

  // Return all strobes high and release the data pins
  function automatic dram_pins_s idle_pins(input dram_pins_s p);
    dram_pins_s r;
    r = p;
    r.ras_n = 1'b1;
    r.cas_n = 1'b1;
    r.we_n = 1'b1;
    r.oe_n = 1'b1;
    r.dq_oe = 1'b0;
    return r;
  endfunction

  // ---------------------------------------------------------------
  // Strobe sequencing and test procedure
  // ---------------------------------------------------------------
  always_comb begin
    next_seq = seq;
    next_pin = pin;
    next_op = op;
    next_pins = pins;
    next_cnt = cnt;
    next_col = col;
    next_pat = pat;
    next_second = second;
    next_busy = busy;
    next_done = done;
    next_fail = fail;
    next_ref_pend = ref_pend;
    next_wt = (wt != 8'h00) ? wt - 8'h01 : 8'h00;
    next_ref_t = (ref_t == 9'(REF_CYC - 1)) ? 9'h000 : ref_t + 9'h001;
    op_done = 1'b0;

    unique case (pin)
      P_IDLE: begin
      end
      P_CBR_CAS: begin
        if (wt == 8'h00) begin
          next_pins.ras_n = 1'b0;
          next_wt = cyc(`RAS_CYC);
          next_pin = P_CBR_RAS;
        end
      end
      P_CBR_RAS: begin
        if (wt == 8'h00) begin
          if (op == OP_CTEST) begin
            next_pins.cas_n = 1'b1;
            next_pins.oe_n = 1'b0;
            next_wt = cyc(`CPN_CYC);
            next_pin = P_CT_UP;
          end else begin
            next_pins = idle_pins(pins);
            next_wt = cyc(`RP_CYC);
            next_pin = P_END;
          end
        end
      end
      P_CT_UP: begin
        // Column goes out after the column precharge wait; the test column delay then runs before the strobe falls
        if (wt == 8'h00) begin
          next_pins.addr = col;
          next_wt = cyc(`CADT_CYC);
          next_pin = P_COL;
        end
      end
      P_ROW: begin
        next_pins.ras_n = 1'b0;
        next_wt = cyc(`RAH_CYC);
        next_pin = P_RAS;
      end
      P_RAS: begin
        if (wt == 8'h00) begin
          next_pins.addr = col;
          if (op == OP_WRITE) begin
            next_pins.we_n = 1'b0;
            next_pins.dq = {4{pat}};
            next_pins.dq_oe = 1'b1;
          end else begin
            next_pins.oe_n = 1'b0;
          end
          next_wt = 8'h00;
          next_pin = P_COL;
        end
      end
      P_COL: begin
        if (wt == 8'h00) begin
          next_pins.cas_n = 1'b0;
          next_wt = (op == OP_WRITE) ? cyc(`CAS_CYC) : cyc(`RD_CYC);
          next_pin = P_CAS;
        end
      end
      P_CAS: begin
        if (wt == 8'h00) begin
          if (op != OP_WRITE && dq_sync != ((op == OP_CTEST) ? {4{pat}} : {4{~pat}})) begin
            next_fail = 1'b1;
          end
          if (op == OP_CTEST) begin
            next_pins.oe_n = 1'b1;
            next_pins.we_n = 1'b0;
            next_pins.dq = {4{~pat}};
            next_pins.dq_oe = 1'b1;
            next_wt = cyc(`CWL_CYC);
            next_pin = P_WE;
          end else if (op == OP_READ && ref_pend) begin
            // Column strobe stays low so the read data stays valid
            next_pins.ras_n = 1'b1;
            next_ref_pend = 1'b0;
            next_wt = cyc(`RP_CYC);
            next_pin = P_HID_UP;
          end else begin
            next_pins = idle_pins(pins);
            next_wt = cyc(`RP_CYC);
            next_pin = P_END;
          end
        end
      end
      P_HID_UP: begin
        if (wt == 8'h00) begin
          next_pins.ras_n = 1'b0;
          next_wt = cyc(`RAS_CYC);
          next_pin = P_HID_DN;
        end
      end
      P_WE, P_HID_DN: begin
        if (wt == 8'h00) begin
          next_pins = idle_pins(pins);
          next_wt = cyc(`RP_CYC);
          next_pin = P_END;
        end
      end
      P_END: begin
        if (wt == 8'h00) begin
          next_pin = P_IDLE;
          op_done = 1'b1;
        end
      end
    endcase

    // Extra refreshes inside the write pass do not count as steps
    if (op_done && !(op == OP_CBR && seq != S_INIT)) begin
      next_cnt = cnt + 9'h001;
      unique case (seq)
        S_INIT: begin
          if (cnt == 9'(INIT_CYCLES - 1)) begin
            next_cnt = 9'h000;
            next_seq = S_WRITE;
          end
        end
        S_WRITE: begin
          if (cnt == `LAST_ROW) begin
            next_cnt = 9'h000;
            next_seq = S_CTEST;
          end
        end
        S_CTEST: begin
          if (cnt == `LAST_ROW) begin
            next_cnt = 9'h000;
            next_seq = S_READ;
          end
        end
        S_READ: begin
          if (cnt == `LAST_ROW) begin
            next_cnt = 9'h000;
            if (second) begin
              next_seq = S_DONE;
              next_busy = 1'b0;
              next_done = 1'b1;
            end else begin
              next_second = 1'b1;
              next_pat = ~pat;
              next_seq = S_WRITE;
            end
          end
        end
        S_IDLE, S_DONE: begin
          next_cnt = cnt;
        end
      endcase
    end

    if (pin == P_IDLE) begin
      if ((seq == S_IDLE || seq == S_DONE) && start_in) begin
        next_col = col_in;
        next_cnt = 9'h000;
        next_pat = 1'b0;
        next_second = 1'b0;
        next_fail = 1'b0;
        next_done = 1'b0;
        next_busy = 1'b1;
        next_seq = S_INIT;
      end else if (seq == S_INIT || seq == S_CTEST || (seq != S_READ && ref_pend)) begin
        // Every strobe-order cycle refreshes one row, so it clears the debt
        next_op = (seq == S_CTEST) ? OP_CTEST : OP_CBR;
        next_pins.cas_n = 1'b0;
        next_ref_pend = 1'b0;
        next_wt = cyc(`CSR_CYC);
        next_pin = P_CBR_CAS;
      end else if (seq == S_WRITE || seq == S_READ) begin
        next_op = (seq == S_WRITE) ? OP_WRITE : OP_READ;
        next_pins.addr = cnt[7:0];
        next_wt = 8'h00;
        next_pin = P_ROW;
      end
    end

    // A tick that meets a clear still leaves the refresh owed
    if (ref_t == 9'(REF_CYC - 1)) begin
      next_ref_pend = 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      seq <= S_IDLE;
      pin <= P_IDLE;
      op <= OP_CBR;
      pins <= '{ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, addr: 8'h00, dq: 4'h0, dq_oe: 1'b0};
      wt <= 8'h00;
      cnt <= 9'h000;
      ref_t <= 9'h000;
      col <= 8'h00;
      pat <= 1'b0;
      second <= 1'b0;
      ref_pend <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
      fail <= 1'b0;
    end else begin
      seq <= next_seq;
      pin <= next_pin;
      op <= next_op;
      pins <= next_pins;
      wt <= next_wt;
      cnt <= next_cnt;
      ref_t <= next_ref_t;
      col <= next_col;
      pat <= next_pat;
      second <= next_second;
      ref_pend <= next_ref_pend;
      busy <= next_busy;
      done <= next_done;
      fail <= next_fail;
    end
  end

  assign pins_out = pins;
  assign busy_out = busy;
  assign done_out = done;
  assign fail_out = fail;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_hidden_cas_low: assert property (@(posedge clk_in) disable iff (rst_in)
    (pin == P_HID_UP) |-> pins.cas_n == 1'b0 && pins.ras_n == 1'b1 ##1 pins.cas_n == 1'b0)
    else $error("column strobe rose during hidden refresh");
  a_ctest_toggle: assert property (@(posedge clk_in) disable iff (rst_in)
    (op == OP_CTEST && $rose(pins.cas_n) && !pins.ras_n) |-> $past(pins.cas_n, 2) == 1'b0)
    else $error("test access without prior strobe-order refresh");
  a_ctest_column: assert property (@(posedge clk_in) disable iff (rst_in)
    (op == OP_CTEST && $fell(pins.cas_n) && !pins.ras_n) |-> pins.addr == col && $past(pins.addr == col))
    else $error("test column not held before column strobe");
  a_init_eight: assert property (@(posedge clk_in) disable iff (rst_in)
    (seq == S_INIT && next_seq == S_WRITE) |-> cnt == 9'(INIT_CYCLES - 1) && op == OP_CBR)
    else $error("initialisation refresh count wrong");
  a_fixed_column: assert property (@(posedge clk_in) disable iff (rst_in)
    ($fell(pins.cas_n) && !pins.ras_n && seq != S_IDLE && seq != S_DONE) |-> pins.addr == col)
    else $error("column address differs from fixed column");
  a_write_pattern: assert property (@(posedge clk_in) disable iff (rst_in)
    (op == OP_WRITE && $fell(pins.cas_n)) |-> !pins.we_n && pins.dq_oe && pins.dq == {4{pat}})
    else $error("write data not the current pattern");
  a_rmw_inverse: assert property (@(posedge clk_in) disable iff (rst_in)
    (op == OP_CTEST && $fell(pins.we_n)) |-> pins.dq == {4{~pat}} && pins.dq_oe && !pins.cas_n && !pins.ras_n
    ##1 pins.dq == {4{~pat}})
    else $error("test access wrote wrong value");
  a_read_we_high: assert property (@(posedge clk_in) disable iff (rst_in)
    (op == OP_READ && !pins.cas_n) |-> pins.we_n && !pins.dq_oe)
    else $error("read cycle with write strobe low");
  a_refresh_served: assert property (@(posedge clk_in) disable iff (rst_in)
    $rose(ref_pend) |-> ##[1:40] !ref_pend)
    else $error("owed refresh not issued in time");
endmodule

// File: rtl/dram_test_regs.svh
// Timing counts and fixed figures for the DRAM counter test controller
`ifndef DRAM_TEST_REGS_SVH
`define DRAM_TEST_REGS_SVH

`define CLK_NS 40
`define RP_NS 80
`define RAS_NS 120
`define RAH_NS 15
`define CSR_NS 15
`define CPN_NS 15
`define CADT_NS 40
`define CAC_NS 35
`define CAS_NS 35
`define CWL_NS 25
`define SYNC_CYC 3
`define RP_CYC ((`RP_NS + `CLK_NS - 1) / `CLK_NS)
`define RAS_CYC ((`RAS_NS + `CLK_NS - 1) / `CLK_NS)
`define RAH_CYC ((`RAH_NS + `CLK_NS - 1) / `CLK_NS)
`define CSR_CYC ((`CSR_NS + `CLK_NS - 1) / `CLK_NS)
`define CPN_CYC ((`CPN_NS + `CLK_NS - 1) / `CLK_NS)
`define CADT_CYC ((`CADT_NS + `CLK_NS - 1) / `CLK_NS)
`define CAS_CYC ((`CAS_NS + `CLK_NS - 1) / `CLK_NS)
`define CWL_CYC ((`CWL_NS + `CLK_NS - 1) / `CLK_NS)
// The synchroniser's voted output register adds one cycle after its three stages
`define RD_CYC (((`CAC_NS + `CLK_NS - 1) / `CLK_NS) + `SYNC_CYC + 1)
`define REF_WINDOW_NS 4000000
`define REF_ROWS 256
`define REF_CYC (`REF_WINDOW_NS / `REF_ROWS / `CLK_NS)
`define INIT_CYCLES 8
`define LAST_ROW 9'h00FF

`endif

// File: rtl/dram_test_pkg.sv
// Types shared by the DRAM counter test controller
package dram_test_pkg;

  typedef struct packed {
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic oe_n;
    logic [7:0] addr;
    logic [3:0] dq;
    logic dq_oe;
  } dram_pins_s;

  typedef enum logic [2:0] {S_IDLE, S_INIT, S_WRITE, S_CTEST, S_READ, S_DONE} seq_e;
  typedef enum logic [3:0] {P_IDLE, P_CBR_CAS, P_CBR_RAS, P_CT_UP, P_ROW, P_RAS, P_COL, P_CAS, P_WE,
                            P_HID_UP, P_HID_DN, P_END} pin_e;
  typedef enum logic [1:0] {OP_CBR, OP_WRITE, OP_READ, OP_CTEST} op_e;

endpackage

// File: rtl/dram_pin_sync.sv
// Three-stage synchroniser for data pins coming back from the DRAM
`timescale 1ns/1ps
module dram_pin_sync #(
  parameter int W = 4
) (
  input wire logic clk_in, // System clock
  input wire logic rst_in, // Synchronous reset, active high
  input wire logic [W-1:0] d_in, // Pin levels
  output logic [W-1:0] q_out // Settled levels
);
  logic [W-1:0] s1, s2, s3, q;
  logic [W-1:0] next_q;

  // Only the later two stages vote; the first stage may be metastable
  always_comb begin
    next_q = q;
    if (s2 == s3) begin
      next_q = s3;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      q <= '0;
    end else begin
      s1 <= d_in;
      s2 <= s1;
      s3 <= s2;
      q <= next_q;
    end
  end

  assign q_out = q;
endmodule

// File: test/dram_x4_model.sv
// Behavioural 64K x 4 DRAM with strobe-order refresh counter and counter test access
`timescale 1ns/1ps
module dram_x4_model
  import dram_test_pkg::*;
(
  input wire dram_test_pkg::dram_pins_s pins_in, // Strobes, address and write data
  input wire logic stuck_in, // Fault: refresh counter does not advance
  input wire logic clr_in, // Clears the statistics
  output logic [3:0] dq_out // Read data
);
  logic [3:0] mem [0:65535];
  logic [7:0] rc = 8'h00;
  logic [7:0] row, col, col0;
  logic [3:0] rdata = 4'h0;
  logic cbr = 1'b0;
  logic armed = 1'b0;
  logic ct = 1'b0;
  logic col_set = 1'b0;
  logic rd_live = 1'b0;
  int n_cbr, n_hid, n_wr, n_rd, n_ct, n_rmw, n_badcol, n_init;

  // -----------------------------------------------
  // Strobe edge behaviour
  // -----------------------------------------------
  // Released pins show the inverse of the last read, so a stale value never passes
  assign dq_out = (!pins_in.cas_n && !pins_in.oe_n && pins_in.we_n) ? rdata : ~rdata;

  task automatic store();
    if (ct && rdata === ~pins_in.dq) n_rmw++;
    if (!ct && n_wr == 0) n_init = n_cbr;
    if (!ct) n_wr++;
    mem[{row, col}] = pins_in.dq;
  endtask

  always @(posedge clr_in) begin
    {n_cbr, n_hid, n_wr, n_rd, n_ct, n_rmw, n_badcol, n_init} = '0;
    col_set = 1'b0;
  end

  always @(negedge pins_in.ras_n) begin
    cbr = !pins_in.cas_n;
    if (cbr) begin
      row = rc;
      n_cbr++;
      if (rd_live) n_hid++;
    end else begin
      row = pins_in.addr;
    end
  end

  always @(posedge pins_in.ras_n) begin
    if (cbr && !stuck_in) rc = rc + 8'h01;
    {cbr, armed, ct} = 3'b000;
  end

  always @(posedge pins_in.cas_n) begin
    rd_live = 1'b0;
    if (!pins_in.ras_n && cbr) armed = 1'b1;
  end

  always @(negedge pins_in.cas_n) begin
    if (!pins_in.ras_n) begin
      ct = armed;
      col = pins_in.addr;
      if (!col_set) col0 = col;
      col_set = 1'b1;
      if (col !== col0) n_badcol++;
      rdata = mem[{row, col}];
      if (ct) n_ct++;
      if (pins_in.we_n) begin
        if (!ct) n_rd++;
        rd_live = 1'b1;
      end else begin
        store();
      end
    end
  end

  // Write lands on the later of the column strobe and write strobe falls
  always @(negedge pins_in.we_n) begin
    if (!pins_in.cas_n && !pins_in.ras_n) store();
  end
endmodule

// File: test/tb_top.sv
// Self-checking bench for the DRAM refresh counter test controller
`timescale 1ns/1ps
module tb_top;
  import dram_test_pkg::*;
  localparam int REF = 60;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic start_in = 1'b0;
  logic [7:0] col_in = 8'h00;
  logic stuck = 1'b0;
  logic clr = 1'b0;
  logic [3:0] dq;
  dram_pins_s pins;
  logic busy, done, fail;
  int error_cnt = 0;
  int n_checks = 0;

  always #20 clk_in = ~clk_in;

  dram_counter_tester #(.REF_CYC(REF), .INIT_CYCLES(8)) i_dut (
    .clk_in(clk_in), .rst_in(rst_in), .start_in(start_in), .col_in(col_in), .dq_in(dq),
    .pins_out(pins), .busy_out(busy), .done_out(done), .fail_out(fail));

  dram_x4_model i_dram (.pins_in(pins), .stuck_in(stuck), .clr_in(clr), .dq_out(dq));

  // -----------------------------------------------
  // Shared tasks
  // -----------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t ns: %s seen %0h expected %0h", $time, msg, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Inputs always move 1 ns after the rising edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  task automatic pulse_clr();
    clr = 1'b1;
    cyc(1);
    clr = 1'b0;
  endtask

  // -----------------------------------------------
  // Scenarios
  // -----------------------------------------------
  task automatic t_idle();
    pulse_clr();
    cyc(5 * REF + 10);
    check(i_dram.n_cbr, 5, "idle refresh count");
    check(i_dram.n_wr + i_dram.n_rd + i_dram.n_ct, 0, "accesses while idle");
  endtask

  // Full two-pass counter test; a stuck device counter must be reported
  task automatic t_run(input logic [7:0] col, input logic stk, input logic exp_fail);
    int k;
    pulse_clr();
    col_in = col;
    stuck = stk;
    start_in = 1'b1;
    k = 0;
    while (busy !== 1'b1 && k < 20) begin
      cyc(1);
      k++;
    end
    start_in = 1'b0;
    check({busy, done, fail}, 3'b100, "flags after start");
    cyc(200);
    start_in = 1'b1;
    cyc(3);
    start_in = 1'b0;
    check({busy, done}, 2'b10, "start while busy");
    k = 0;
    while (done !== 1'b1 && k < 30000) begin
      cyc(1);
      k++;
    end
    check({busy, done, fail}, {2'b01, exp_fail}, "end state");
    if (!stk) begin
      check(i_dram.n_init >= 8, 1, "refreshes before first write");
      check(i_dram.n_wr, 512, "normal writes");
      check(i_dram.n_ct, 512, "counter test accesses");
      check(i_dram.n_rmw, 512, "read zero write one");
      check(i_dram.n_rd, 512, "normal reads");
      check(i_dram.n_hid > 0, 1, "hidden refresh during read");
      check(i_dram.n_badcol, 0, "column changed");
      for (int r = 0; r < 256; r++) begin
        check(i_dram.mem[{r[7:0], col}], 4'h0, "final cell");
      end
    end
    stuck = 1'b0;
  endtask

  initial begin
    cyc(2);
    check(pins, 17'h1_E000, "pins in reset");
    check({busy, done, fail}, 3'b000, "flags in reset");
    rst_in = 1'b0;
    t_idle();
    t_run(8'hA5, 1'b0, 1'b0);
    t_run(8'h3C, 1'b1, 1'b1);
    t_run(8'hFF, 1'b0, 1'b0);
    finish_test();
  end

  // Three runs take some 50k cycles; a hang is cut at 95k
  initial begin
    cyc(95000);
    error_cnt++;
    $display("unexpected at %0t ns: watchdog expired", $time);
    finish_test();
  end
endmodule
